// ---- dv/smc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module smc_host_model (
  // Clock
  input wire logic clk_i,
  // Commands from the bench
  input wire logic want_sleep_i,
  input wire logic chatter_i,
  // Pins toward the device
  output var logic sleep_request_in_o = 1'b0,
  output var logic serial_activity_o = 1'b0
);
  // Drives a single node; never mixes async and sync sleepers
  logic [1:0] gap_r = 2'h0;
  ////////////////////////////////////////////////////////////////////////////
  // Request pin moves only after an edge, high asks for sleep, low wakes
  always_ff @(posedge clk_i) begin
    sleep_request_in_o <= want_sleep_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Serial traffic every third cycle, so a brief wake still sees data
  always_ff @(posedge clk_i) begin
    gap_r <= (gap_r == 2'h2) ? 2'h0 : gap_r + 2'h1;
    serial_activity_o <= chatter_i && (gap_r == 2'h0);
  end
endmodule : smc_host_model
`default_nettype wire

// ---- dv/smc_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end
module tb;
  // Short tick keeps every cycle count small
  localparam int TICK = 4;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic busy_i = 1'b0;
  logic sync_rx_i = 1'b0;
  logic [15:0] sync_sleep_i = 16'h0000;
  logic [15:0] sync_wake_i = 16'h0000;
  logic want_sleep = 1'b0;
  logic chatter = 1'b0;
  logic radio_act = 1'b0;
  logic join_req = 1'b0;
  logic sync_tx_o;
  logic [15:0] sync_sleep_o, sync_wake_o;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, awake_o, cts_n_o, serial_accept_o, radio_rx_en_o;
  logic data_tx_allow_o, poll_o, sync_relay_o, sync_req_o;
  logic sleep_request_in_i, serial_activity_i;
  logic [32:0] exp_q[$];
  logic [32:0] exp_n;
  int num_errors = 0;
  int n_checks = 0;
  int waited = 0;
  int hits = 0;

  smc_sleep_ctrl #(.TW(16), .TICK_CYCLES(TICK)) smc_sleep_ctrl_inst (
    .clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .sleep_request_in_i, .awake_o, .cts_n_o, .serial_activity_i,
    .radio_activity_i(radio_act), .busy_i, .serial_accept_o, .radio_rx_en_o, .data_tx_allow_o,
    .poll_o, .sync_rx_i, .sync_sleep_i, .sync_wake_i, .join_req_i(join_req), .sync_tx_o,
    .sync_relay_o, .sync_req_o, .sync_sleep_o, .sync_wake_o
  );
  smc_host_model smc_host_model_inst (
    .clk_i, .want_sleep_i(want_sleep), .chatter_i(chatter),
    .sleep_request_in_o(sleep_request_in_i), .serial_activity_o(serial_activity_i)
  );

  always #5 clk_i = ~clk_i;
  //////////////////////////////////////////////////////////////////////////////
  // Bus monitor: oldest note against each completed transfer
  always @(posedge clk_i) begin
    if (psel_i && penable_i && pready_o === 1'b1) begin
      exp_n = exp_q.pop_front();
      `CHK(pslverr_o, exp_n[32])
      if (!pwrite_i) `CHK(prdata_o, exp_n[31:0])
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic fail_out;
    num_errors++;
    $display("CHECK FAILED %0t wait ran out", $time);
    report_and_stop();
  endtask : fail_out

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] ex);
    int k;
    exp_q.push_back(ex);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (pready_o !== 1'b1) fail_out();
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d, {e, 32'h0000_0000});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b0, a, 32'h0000_0000, {e, d});
  endtask : rd

  function automatic logic pick(input int s);
    case (s)
      0: pick = awake_o;
      1: pick = cts_n_o;
      2: pick = sync_req_o;
      3: pick = sync_relay_o;
      default: pick = sync_tx_o;
    endcase
  endfunction : pick

  // Bounded wait for a level, cycles spent left in waited
  task automatic wait_on(input int s, input logic v, input int lim);
    waited = 0;
    while (pick(s) !== v && waited < lim) begin
      @(negedge clk_i);
      waited++;
    end
    if (pick(s) !== v) fail_out();
  endtask : wait_on

  task automatic hold_awake(input int n);
    int lows;
    lows = 0;
    repeat (n) begin
      @(negedge clk_i);
      lows += (awake_o !== 1'b1);
    end
    `CHK(lows, 0)
  endtask : hold_awake

  // Cycles out of n in which the chosen output is high
  task automatic count_hi(input int s, input int n);
    hits = 0;
    repeat (n) begin
      @(negedge clk_i);
      hits += (pick(s) === 1'b1);
    end
  endtask : count_hi

  initial begin
    #900000;
    fail_out();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    int s_t;
    int w_t;
    logic [3:0] never_m[2];
    never_m = '{smc_pkg::M_NORM, smc_pkg::M_SUP};
    void'($urandom(7));
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(8'h00, 32'h0000_0020, 1'b0);
    rd(8'h04, 32'h0000_0064, 1'b0);
    rd(8'h08, 32'h0000_0010, 1'b0);
    rd(8'h0C, 32'h0000_0064, 1'b0);
    rd(8'h10, 32'h0000_0010, 1'b0);
    rd(8'h18, 32'h0000_0000, 1'b1);
    wr(8'h0C, 32'h0000_FFFF, 1'b1);
    @(negedge clk_i);
    `CHK({cts_n_o, data_tx_allow_o}, 2'b01)
    $display("test registers done");
    // Sleep request has no effect where the mode never sleeps
    want_sleep <= 1'b1;
    foreach (never_m[i]) begin
      wr(8'h00, {24'h0, 4'h2, never_m[i]}, 1'b0);
      hold_awake(80);
    end
    // Non-coordinator option silences a preferred coordinator
    wr(8'h00, 32'h0000_01A7, 1'b0);
    count_hi(4, 20);
    `CHK(hits, 0)
    `CHK(data_tx_allow_o, 1'b0)
    wr(8'h00, 32'h0000_0127, 1'b0);
    count_hi(4, 3);
    `CHK(hits, 1)
    `CHK(data_tx_allow_o, 1'b1)
    @(posedge clk_i);
    join_req <= 1'b1;
    @(posedge clk_i);
    join_req <= 1'b0;
    count_hi(4, 3);
    `CHK(hits, 1)
    $display("test never sleep done");
    // Pin sleep: an ongoing transfer holds entry
    @(posedge clk_i);
    busy_i <= 1'b1;
    wr(8'h00, 32'h0000_0071, 1'b0);
    wait_on(1, 1'b1, 40);
    hold_awake(10);
    @(posedge clk_i);
    busy_i <= 1'b0;
    wait_on(0, 1'b0, 10);
    `CHK({cts_n_o, serial_accept_o}, 2'b10)
    @(posedge clk_i);
    want_sleep <= 1'b0;
    wait_on(0, 1'b1, 20);
    `CHK(poll_o, 1'b1)
    $display("test pin sleep done");
    // Timed cycle with short periods
    wr(8'h04, 32'h0000_0008, 1'b0);
    wr(8'h08, 32'h0000_0004, 1'b0);
    wr(8'h00, 32'h0000_0024, 1'b0);
    wait_on(0, 1'b0, 100);
    wait_on(0, 1'b1, 8 * TICK + 20);
    wait_on(0, 1'b0, 2 * TICK + 4);
    @(posedge clk_i);
    chatter <= 1'b1;
    wait_on(0, 1'b1, 100);
    hold_awake(60);
    @(posedge clk_i);
    chatter <= 1'b0;
    radio_act <= 1'b1;
    hold_awake(30);
    @(posedge clk_i);
    radio_act <= 1'b0;
    wait_on(0, 1'b0, 4 * TICK + 20);
    `CHK(waited >= 3 * TICK, 1'b1)
    $display("test cyclic done");
    // Cycling under request, pin release wakes for good
    wr(8'h00, 32'h0000_0025, 1'b0);
    wait_on(0, 1'b1, 20);
    @(posedge clk_i);
    want_sleep <= 1'b1;
    wait_on(0, 1'b0, 100);
    wait_on(0, 1'b1, 100);
    wait_on(0, 1'b0, 20);
    @(posedge clk_i);
    want_sleep <= 1'b0;
    wait_on(0, 1'b1, 12);
    hold_awake(100);
    $display("test pin wake done");
    // Network cycle: request sync, adopt carried timing
    s_t = 4 + ($urandom % 8);
    w_t = 2 + ($urandom % 4);
    wr(8'h00, 32'h0000_0028, 1'b0);
    wait_on(2, 1'b1, 200);
    @(posedge clk_i);
    sync_rx_i <= 1'b1;
    sync_sleep_i <= 16'(s_t);
    sync_wake_i <= 16'(w_t);
    @(posedge clk_i);
    sync_rx_i <= 1'b0;
    count_hi(3, 3);
    `CHK(hits, 1)
    rd(8'h0C, {16'h0, 16'(s_t)}, 1'b0);
    rd(8'h10, {16'h0, 16'(w_t)}, 1'b0);
    wait_on(0, 1'b0, 100);
    `CHK({serial_accept_o, radio_rx_en_o}, 2'b00)
    `CHK({sync_sleep_o, sync_wake_o}, {16'(s_t), 16'(w_t)})
    wr(8'h04, {16'h0, 16'(s_t + 1)}, 1'b0);
    rd(8'h0C, {16'h0, 16'(s_t + 1)}, 1'b0);
    $display("test sync cycle done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire

// ---- src/smc_defs.svh ----
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH
// Timing
`define SMC_CLK_NS 10
`define SMC_TICK_NS 1000000
`define SMC_BRIEF 16'h0001
// Register byte offsets
`define SMC_A_CTRL 8'h00
`define SMC_A_SLP 8'h04
`define SMC_A_WAK 8'h08
`define SMC_A_OSLP 8'h0C
`define SMC_A_OWAK 8'h10
`define SMC_A_STAT 8'h14
// Control field positions
`define SMC_F_MODE 0
`define SMC_F_FLOW 4
`define SMC_F_IND 5
`define SMC_F_POLL 6
`define SMC_F_NONC 7
`define SMC_F_PREF 8
// Reset values
`define SMC_R_MODE 4'h0
`define SMC_R_IND 1'b1
`define SMC_R_SLP 16'h0064
`define SMC_R_WAK 16'h0010
`endif

// ---- src/smc_pkg.sv ----
package smc_pkg;
  typedef enum logic [1:0] {
    ST_AWAKE = 2'b00,
    ST_DRAIN = 2'b01,
    ST_ASLEEP = 2'b11
  } smc_state_t;
  typedef enum logic [3:0] {
    M_NORM = 4'h0,
    M_PIN = 4'h1,
    M_CYC = 4'h4,
    M_CYCPIN = 4'h5,
    M_SUP = 4'h7,
    M_SYNC = 4'h8
  } smc_mode_t;
endpackage : smc_pkg

// ---- src/smc_sleep_ctrl.sv ----
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "smc_defs.svh"
// Contract
// [R1] Mode 0 never sleeps and is default; 1,4,5 asynchronous; 7,8 synchronous.
// [R2] Mode 0 routes data always; relays sync once synced, never originates one.
// [R3] Mode 1: request high sleeps after ongoing transfer completes.
// [R4] Mode 1: request low wakes the device.
// [R5] Asynchronous modes with polling send one poll on each wake.
// [R6] Mode 4 sleeps a period, wakes briefly, resleeps if no data.
// [R7] Awake indicator high while awake, low while asleep.
// [R8] With flow control, clear-to-send low when awake and accepting, else high.
// [R9] Mode 5 cycles as mode 4 while requested; wakes and stays awake otherwise.
// [R10] Mode 7 syncs, never sleeps, sends data only in network wake.
// [R11] Mode 7 answers joining nodes with a sync at any time.
// [R12] Mode 8 wakes with the network, exchanges data and sync, sleeps.
// [R13] Asleep in mode 8: no radio reception, no serial input.
// [R14] Local timing used until synced, then timing carried by sync messages.
// [R15] Applied sleep and wake times readable through two read-only registers.
// [R16] Unsynced mode 8 requests sync then sleeps local period, until synced.
// [R17] Modes 4,5: data restarts wake-time countdown; expiry sends device to sleep.
// [R18] Coordinator sends one sync per wake start; receivers rebroadcast it.
// [R19] Most recently set sleep and wake times are the ones applied.
// [R20] Non-coordinator option forbids acting as sleep coordinator.
// [R21] Builders should not mix async and sync sleepers or route via async.
// [R22] Timers count a divided tick derived from the device clock.
module smc_sleep_ctrl #(
  parameter int TW = 16,
  parameter int TICK_CYCLES = `SMC_TICK_NS / `SMC_CLK_NS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Host pins
  input wire logic sleep_request_in_i,
  output logic awake_o,
  output logic cts_n_o,
  // Data path
  input wire logic serial_activity_i,
  input wire logic radio_activity_i,
  input wire logic busy_i,
  output logic serial_accept_o,
  output logic radio_rx_en_o,
  output logic data_tx_allow_o,
  output logic poll_o,
  // Network sync
  input wire logic sync_rx_i,
  input wire logic [TW-1:0] sync_sleep_i,
  input wire logic [TW-1:0] sync_wake_i,
  input wire logic join_req_i,
  output logic sync_tx_o,
  output logic sync_relay_o,
  output logic sync_req_o,
  output logic [TW-1:0] sync_sleep_o,
  output logic [TW-1:0] sync_wake_o
);

  localparam int CW = $clog2(TICK_CYCLES);

  if (TW < 2 || TW > 32 || TICK_CYCLES < 2) begin : g_bad
    $error("smc_sleep_ctrl: unsupported parameters");
  end

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [3:0] mode_r;
  logic flow_en_r;
  logic ind_en_r;
  logic poll_en_r;
  logic non_coord_r;
  logic pref_coord_r;
  logic [TW-1:0] sleep_period_r;
  logic [TW-1:0] wake_time_r;
  logic [TW-1:0] op_sleep_r;
  logic [TW-1:0] op_wake_r;
  logic [31:0] prdata_r;
  logic req_s1_r;
  logic req_s2_r;
  logic req_s3_r;
  logic req_r;
  logic [CW-1:0] tick_cnt_r;
  logic tick;
  smc_pkg::smc_state_t state_r;
  smc_pkg::smc_state_t state_nxt;
  logic [TW-1:0] cnt_r;
  logic cnt_zero;
  logic synced_r;
  logic net_wake_r;
  logic [TW-1:0] ncnt_r;
  logic m_pin, m_cyc, m_cycpin, m_sup, m_sync, m_norm;
  logic m_async, m_track, cyc_mode, coord;
  logic awake, act, sync_ok, wake_start;
  logic sleep_go, wake_go, woke, fall_asleep;
  logic poll_r, sync_tx_r, relay_r, sync_req_r;
  logic setup, access, wr, bad;
  logic [31:0] rd_val;

  ////////////////////////////////////////////////////////////////////////
  // Mode decode; unknown codes behave as mode 0
  always_comb begin
    m_pin = mode_r == smc_pkg::M_PIN; // [R1]
    m_cyc = mode_r == smc_pkg::M_CYC;
    m_cycpin = mode_r == smc_pkg::M_CYCPIN;
    m_sup = mode_r == smc_pkg::M_SUP;
    m_sync = mode_r == smc_pkg::M_SYNC;
    m_async = m_pin | m_cyc | m_cycpin;
    m_norm = !(m_async | m_sup | m_sync); // [R1]
    m_track = m_norm | m_sup | m_sync;
  end

  // Only sync-mode nodes may coordinate
  assign coord = pref_coord_r & !non_coord_r & (m_sup | m_sync); // [R20]
  assign cyc_mode = m_cyc | (m_cycpin & req_r) | (m_sync & !synced_r); // [R6] [R9] [R16]

  ////////////////////////////////////////////////////////////////////////
  // Sleep request pin: three flops, change taken when last two agree
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
      req_r <= 1'b0;
    end else begin
      req_s1_r <= sleep_request_in_i;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
      if (req_s2_r == req_s3_r) begin
        req_r <= req_s3_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timer tick; one tick per TICK_CYCLES clocks
  assign tick = tick_cnt_r == CW'(TICK_CYCLES - 1); // [R22]

  always_ff @(posedge clk_i) begin
    if (srst_i || tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sleep state machine
  assign awake = state_r != smc_pkg::ST_ASLEEP;
  assign cnt_zero = cnt_r == '0;
  // Data seen only while the port is open
  assign act = (serial_activity_i & serial_accept_o) | (radio_activity_i & radio_rx_en_o);

  always_comb begin
    sleep_go = 1'b0;
    wake_go = 1'b1;
    if (m_pin) begin
      sleep_go = req_r; // [R3]
      wake_go = !req_r; // [R4]
    end else if (cyc_mode) begin
      sleep_go = cnt_zero; // [R6] [R17]
      wake_go = cnt_zero;
    end else if (m_sync) begin
      sleep_go = !net_wake_r; // [R12]
      wake_go = net_wake_r;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      smc_pkg::ST_AWAKE: if (sleep_go) state_nxt = smc_pkg::ST_DRAIN;
      smc_pkg::ST_DRAIN: begin
        // Sleep waits for the ongoing transfer
        if (!sleep_go) begin
          state_nxt = smc_pkg::ST_AWAKE;
        end else if (!busy_i) begin
          state_nxt = smc_pkg::ST_ASLEEP; // [R3]
        end
      end
      smc_pkg::ST_ASLEEP: if (wake_go) state_nxt = smc_pkg::ST_AWAKE;
      default: state_nxt = smc_pkg::ST_AWAKE;
    endcase
  end

  assign woke = (state_r == smc_pkg::ST_ASLEEP) && (state_nxt == smc_pkg::ST_AWAKE);
  assign fall_asleep = (state_r == smc_pkg::ST_DRAIN) && (state_nxt == smc_pkg::ST_ASLEEP);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= smc_pkg::ST_AWAKE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Countdown for the local sleep/wake cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_r <= '0;
    end else if (woke) begin
      cnt_r <= TW'(`SMC_BRIEF); // [R6]
    end else if (fall_asleep) begin
      cnt_r <= sleep_period_r; // [R6] [R16]
    end else if (state_r == smc_pkg::ST_AWAKE && act && (m_cyc | m_cycpin)) begin
      cnt_r <= wake_time_r; // [R17]
    end else if (tick && !cnt_zero) begin
      cnt_r <= cnt_r - 1'b1; // [R22]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Network sync tracking
  assign sync_ok = sync_rx_i & radio_rx_en_o & m_track & !coord;
  assign wake_start = coord & (!synced_r | (tick & (ncnt_r == '0) & !net_wake_r));

  always_ff @(posedge clk_i) begin
    if (srst_i || !m_track) begin
      synced_r <= 1'b0;
      net_wake_r <= 1'b0;
      ncnt_r <= '0;
    end else if (sync_ok) begin
      synced_r <= 1'b1;
      net_wake_r <= 1'b1;
      ncnt_r <= sync_wake_i; // [R14]
    end else if (coord && !synced_r) begin
      synced_r <= 1'b1;
      net_wake_r <= 1'b1;
      ncnt_r <= op_wake_r;
    end else if (synced_r && tick) begin
      if (ncnt_r == '0) begin
        net_wake_r <= !net_wake_r; // [R12]
        ncnt_r <= net_wake_r ? op_sleep_r : op_wake_r;
      end else begin
        ncnt_r <= ncnt_r - 1'b1;
      end
    end
  end

  // Applied timing: local until synced, then last of sync or local write
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      op_sleep_r <= TW'(`SMC_R_SLP);
      op_wake_r <= TW'(`SMC_R_WAK);
    end else if (sync_ok) begin
      op_sleep_r <= sync_sleep_i; // [R14]
      op_wake_r <= sync_wake_i;
    end else if (!synced_r) begin
      op_sleep_r <= sleep_period_r; // [R14]
      op_wake_r <= wake_time_r;
    end else if (wr && paddr_i == `SMC_A_SLP) begin
      op_sleep_r <= pwdata_i[TW-1:0]; // [R19]
    end else if (wr && paddr_i == `SMC_A_WAK) begin
      op_wake_r <= pwdata_i[TW-1:0]; // [R19]
    end
  end

  // Event pulses
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      poll_r <= 1'b0;
      sync_tx_r <= 1'b0;
      relay_r <= 1'b0;
      sync_req_r <= 1'b0;
      sync_sleep_o <= '0;
      sync_wake_o <= '0;
    end else begin
      poll_r <= woke & m_async & poll_en_r; // [R5]
      // Mode 0 never reaches either term
      sync_tx_r <= wake_start | (join_req_i & synced_r & (m_sup | (m_sync & awake))); // [R2] [R11] [R18]
      relay_r <= sync_ok; // [R2] [R18]
      sync_req_r <= woke & m_sync & !synced_r & !coord; // [R16]
      sync_sleep_o <= op_sleep_r;
      sync_wake_o <= op_wake_r;
    end
  end

  assign poll_o = poll_r;
  assign sync_tx_o = sync_tx_r;
  assign sync_relay_o = relay_r;
  assign sync_req_o = sync_req_r;

  ////////////////////////////////////////////////////////////////////////
  // Pins and data gating
  assign awake_o = ind_en_r & awake; // [R7]
  // Draining counts as not accepting
  assign cts_n_o = flow_en_r & (state_r != smc_pkg::ST_AWAKE); // [R8]
  assign serial_accept_o = awake; // [R13]
  assign radio_rx_en_o = awake; // [R13]

  always_comb begin
    if (m_norm) begin
      data_tx_allow_o = 1'b1; // [R2]
    end else if (m_sup) begin
      data_tx_allow_o = synced_r & net_wake_r; // [R10]
    end else begin
      data_tx_allow_o = state_r == smc_pkg::ST_AWAKE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  assign setup = psel_i & !penable_i;
  assign access = psel_i & penable_i;
  assign pready_o = 1'b1;
  assign wr = access & pwrite_i & !bad;
  assign pslverr_o = access & bad;

  always_comb begin
    bad = 1'b0;
    rd_val = 32'h00000000;
    unique case (paddr_i)
      `SMC_A_CTRL: rd_val = {23'h000000, pref_coord_r, non_coord_r, poll_en_r,
                             ind_en_r, flow_en_r, mode_r};
      `SMC_A_SLP: rd_val = 32'(sleep_period_r);
      `SMC_A_WAK: rd_val = 32'(wake_time_r);
      `SMC_A_OSLP: begin
        rd_val = 32'(op_sleep_r); // [R15]
        bad = pwrite_i;
      end
      `SMC_A_OWAK: begin
        rd_val = 32'(op_wake_r); // [R15]
        bad = pwrite_i;
      end
      `SMC_A_STAT: begin
        rd_val = {26'h0000000, coord, req_r, net_wake_r, synced_r, state_r};
        bad = pwrite_i;
      end
      default: bad = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prdata_r <= 32'h00000000;
    end else if (setup && !pwrite_i) begin
      prdata_r <= rd_val;
    end
  end

  assign prdata_o = prdata_r;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_r <= `SMC_R_MODE; // [R1]
      flow_en_r <= 1'b0;
      ind_en_r <= `SMC_R_IND;
      poll_en_r <= 1'b0;
      non_coord_r <= 1'b0;
      pref_coord_r <= 1'b0;
    end else if (wr && paddr_i == `SMC_A_CTRL) begin
      mode_r <= pwdata_i[`SMC_F_MODE +: 4];
      flow_en_r <= pwdata_i[`SMC_F_FLOW];
      ind_en_r <= pwdata_i[`SMC_F_IND];
      poll_en_r <= pwdata_i[`SMC_F_POLL];
      non_coord_r <= pwdata_i[`SMC_F_NONC];
      pref_coord_r <= pwdata_i[`SMC_F_PREF];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sleep_period_r <= TW'(`SMC_R_SLP);
      wake_time_r <= TW'(`SMC_R_WAK);
    end else if (wr && paddr_i == `SMC_A_SLP) begin
      sleep_period_r <= pwdata_i[TW-1:0];
    end else if (wr && paddr_i == `SMC_A_WAK) begin
      wake_time_r <= pwdata_i[TW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_idle_expire;
    state_r == smc_pkg::ST_AWAKE && m_cyc && cnt_zero && !act;
  endsequence
  sequence s_drain_done;
    state_r == smc_pkg::ST_DRAIN && sleep_go && !busy_i;
  endsequence

  chk_norm_wakes: assert property ( // [R1]
    m_norm && state_r == smc_pkg::ST_ASLEEP |=> state_r == smc_pkg::ST_AWAKE)
    else $error("mode 0 stayed asleep");
  chk_norm_no_sync: assert property ( // [R2]
    m_norm && $past(m_norm) |-> !sync_tx_o)
    else $error("mode 0 originated a sync");
  chk_drain_busy: assert property ( // [R3]
    state_r == smc_pkg::ST_DRAIN && busy_i |=> state_r != smc_pkg::ST_ASLEEP)
    else $error("slept during a transfer");
  chk_pin_wake: assert property ( // [R4]
    m_pin && state_r == smc_pkg::ST_ASLEEP && !req_r |=> state_r == smc_pkg::ST_AWAKE)
    else $error("pin release did not wake");
  chk_poll_wake: assert property ( // [R5]
    $past(state_r) == smc_pkg::ST_ASLEEP && awake && $past(m_async && poll_en_r)
    |-> poll_o)
    else $error("no poll on wake");
  chk_idle_sleep: assert property ( // [R6]
    s_idle_expire ##1 s_drain_done |=> state_r == smc_pkg::ST_ASLEEP)
    else $error("idle wake did not return to sleep");
  chk_ind_fall: assert property ( // [R7]
    ind_en_r && $fell(awake_o) |-> $past(state_r) == smc_pkg::ST_DRAIN && !$past(busy_i))
    else $error("indicator fell without sleep entry");
  chk_cts_accept: assert property ( // [R8]
    flow_en_r && state_r == smc_pkg::ST_ASLEEP |-> cts_n_o && !serial_accept_o)
    else $error("clear-to-send low while asleep");
  chk_cycpin_wake: assert property ( // [R9]
    m_cycpin && !req_r && state_r != smc_pkg::ST_AWAKE |=> state_r == smc_pkg::ST_AWAKE)
    else $error("mode 5 did not wake on release");
  chk_support_tx: assert property ( // [R10]
    m_sup && data_tx_allow_o |-> synced_r && net_wake_r)
    else $error("support node sent outside wake");
  chk_join_reply: assert property ( // [R11]
    m_sup && synced_r && join_req_i |=> sync_tx_o)
    else $error("join not answered");
  chk_sleep_deaf: assert property ( // [R13]
    m_sync && state_r == smc_pkg::ST_ASLEEP |-> !serial_accept_o && !radio_rx_en_o)
    else $error("input open while asleep");
  chk_adopt_time: assert property ( // [R14]
    sync_ok |=> op_sleep_r == $past(sync_sleep_i) && op_wake_r == $past(sync_wake_i))
    else $error("sync timing not adopted");
  chk_op_read: assert property ( // [R15]
    setup && !pwrite_i && paddr_i == `SMC_A_OSLP |=> prdata_o == 32'($past(op_sleep_r)))
    else $error("applied sleep time misread");
  chk_sync_req: assert property ( // [R16]
    woke && m_sync && !synced_r && !coord |=> sync_req_o)
    else $error("no sync request on wake");
  chk_restart: assert property ( // [R17]
    state_r == smc_pkg::ST_AWAKE && act && m_cyc |=> cnt_r == $past(wake_time_r))
    else $error("countdown not restarted");
  chk_coord_sync: assert property ( // [R18]
    wake_start |=> sync_tx_o ##1 !sync_tx_o || $past(join_req_i))
    else $error("coordinator sync not single");
  chk_noncoord: assert property ( // [R20]
    non_coord_r |-> !wake_start)
    else $error("non-coordinator coordinated");

endmodule : smc_sleep_ctrl
`default_nettype wire
